// ---- core/ddtc_top.sv ----
// Dual doze timer control: two inactivity timers, doze state and SMI.
// Activity inputs come from pins or other clocks and are synchronised here.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
module ddtc_top #(
   parameter int TICK_CYCLES = ddtc_pkg::MS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // AXI4-Lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Activity sources
   input wire logic [7:0] deviceActivity,
   input wire logic [15:0] irqLine,
   input wire logic localBusDeviceSelectN,
   input wire logic memIoSel,
   input wire logic externalPowerEventIn,
   input wire logic smiIn,
   input wire logic cpuIntr,
   // Clock control and notification
   output logic slowClock,
   output logic stopCpuClock,
   output logic idleTimeoutSmiEvent,
   output logic irqOut
);
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] ctrlTwo_r, selDev_r, selIrqLo_r, selIrqHi_r, ctrlEleven_r, eventSix_r;
   logic [7:0] dozeCtrl_r, irqMask_r;
   logic [31:0] rstEn_r, smiEn_r;
   logic [ddtc_pkg::STAT_W-1:0] irqStat_r;
   logic awPend_r, wPend_r;
   logic [11:0] awAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wrDo, rdDo;
   logic [7:0] wrIdx, rdIdx;
   logic wrHit, statRead;
   logic [31:0] rdVal;
   logic rdHit;
   ddtc_pkg::ddtc_state_t state_r;
   // ---------------------------------------------------------------
   // Input synchronisers and edge detection
   // ---------------------------------------------------------------
   localparam int PIN_W = ddtc_pkg::SRC_W + 1;
   logic [PIN_W-1:0] pinRaw, syncA_r, syncB_r, prevB_r;
   ddtc_pkg::ddtc_src_t srcNow, srcPrev, fire;
   logic memIoS;
   assign pinRaw = {memIoSel, cpuIntr, smiIn, externalPowerEventIn, ~localBusDeviceSelectN,
                    irqLine, deviceActivity};
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         syncA_r <= '0;
         syncB_r <= '0;
         prevB_r <= '0;
      end else begin
         syncA_r <= pinRaw;
         syncB_r <= syncA_r;
         prevB_r <= syncB_r;
      end
   end
   assign srcNow = ddtc_pkg::ddtc_src_t'(syncB_r[ddtc_pkg::SRC_W-1:0]);
   assign srcPrev = ddtc_pkg::ddtc_src_t'(prevB_r[ddtc_pkg::SRC_W-1:0]);
   assign memIoS = syncB_r[PIN_W-1];
   // ---------------------------------------------------------------
   // Enabled doze reset events
   // ---------------------------------------------------------------
   ddtc_pkg::ddtc_src_t enVec, selVec, smiVec;
   logic [15:0] irqSel;
   assign enVec = ddtc_pkg::ddtc_src_t'(rstEn_r[ddtc_pkg::SRC_W-1:0]);
   assign smiVec = ddtc_pkg::ddtc_src_t'(smiEn_r[ddtc_pkg::SRC_W-1:0]);
   // Low IRQ select order 8,7,6,5,4,3,1,0; IRQ2 is the cascade, primary only
   assign irqSel = {selIrqHi_r[6:0], selIrqLo_r[7:2], 1'b0, selIrqLo_r[1:0]};
   always_comb begin
      selVec = '0;
      selVec.dev = selDev_r;
      selVec.irq = irqSel;
      selVec.local_bus_device_select_n = selIrqHi_r[7];
      selVec.epmi = 1'b0;
      selVec.smi = 1'b0;
      selVec.intr = 1'b0;
   end
   always_comb begin
      fire = srcNow & ~srcPrev & enVec;
      // Display, keyboard, floppy, hard disk share one enable
      fire.dev[7:4] = srcNow.dev[7:4] & ~srcPrev.dev[7:4]
                      & {4{ctrlTwo_r[ddtc_pkg::DEV_RST_EN_BIT]}};
      // Local bus: I/O and memory cycles enabled separately
      fire.local_bus_device_select_n = srcNow.local_bus_device_select_n & ~srcPrev.local_bus_device_select_n
                  & (memIoS ? enVec.local_bus_device_select_n : rstEn_r[ddtc_pkg::SRC_W]);
      fire.epmi = srcNow.epmi & enVec.epmi;
   end
   // ---------------------------------------------------------------
   // Inactivity timers
   // ---------------------------------------------------------------
   logic [ddtc_pkg::CNT_W-1:0] loadVal [2];
   logic [ddtc_pkg::CNT_W-1:0] cnt_r [2];
   logic [1:0] expired_r, expPulse, reload;
   logic initLoad_r, secNoDelay, tick, dozeReset;
   logic [15:0] tickCnt_r;
   assign loadVal[0] = ddtc_pkg::primMs(ctrlTwo_r[ddtc_pkg::TO_MSB:ddtc_pkg::TO_LSB]);
   assign loadVal[1] = ddtc_pkg::secMs(ctrlEleven_r[ddtc_pkg::TO_MSB:ddtc_pkg::TO_LSB]);
   assign secNoDelay = (loadVal[1] == '0);
   assign reload[0] = initLoad_r | (|(fire & ~selVec));
   assign reload[1] = initLoad_r | ((|(fire & selVec)) & ~secNoDelay);
   assign dozeReset = (|(fire & ~selVec)) | ((|(fire & selVec)) & ~secNoDelay);
   assign tick = (tickCnt_r == 16'(TICK_CYCLES - 1));
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt_r <= '0;
         initLoad_r <= 1'b1;
      end else begin
         tickCnt_r <= tick ? '0 : tickCnt_r + 16'h0001;
         initLoad_r <= 1'b0;
      end
   end
   for (genvar t = 0; t < 2; t++) begin : gTimer
      assign expPulse[t] = tick & ~reload[t] & (cnt_r[t] == 13'h0001);
      always_ff @(posedge ref_clk or posedge sys_rst) begin
         if (sys_rst) begin
            cnt_r[t] <= '0;
            expired_r[t] <= 1'b0;
         end else if (reload[t]) begin
            cnt_r[t] <= loadVal[t];
            expired_r[t] <= (loadVal[t] == '0);
         end else if (tick && cnt_r[t] != '0) begin
            cnt_r[t] <= cnt_r[t] - 13'h0001;
            expired_r[t] <= expPulse[t];
         end
      end
   end
   // ---------------------------------------------------------------
   // Doze state
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ddtc_pkg::DOZE_FULL;
      end else begin
         case (state_r)
            ddtc_pkg::DOZE_FULL: begin
               if (dozeCtrl_r[ddtc_pkg::CTL_SW_STOP]) begin
                  state_r <= ddtc_pkg::DOZE_STOP;
               end else if (dozeCtrl_r[ddtc_pkg::CTL_SW_SLOW]) begin
                  state_r <= ddtc_pkg::DOZE_SLOW;
               end else if (dozeCtrl_r[ddtc_pkg::CTL_HW_EN] && (&expired_r)) begin
                  state_r <= ddtc_pkg::DOZE_SLOW;
               end
            end
            default: begin
               if (dozeReset) begin
                  state_r <= ddtc_pkg::DOZE_FULL;
               end
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         slowClock <= 1'b0;
         stopCpuClock <= 1'b0;
      end else begin
         slowClock <= (state_r != ddtc_pkg::DOZE_FULL);
         stopCpuClock <= (state_r == ddtc_pkg::DOZE_STOP);
      end
   end
   // ---------------------------------------------------------------
   // SMI generation
   // ---------------------------------------------------------------
   logic [1:0] smiSel;
   logic smiTo;
   assign smiSel = eventSix_r[ddtc_pkg::SMI_SEL_MSB:ddtc_pkg::SMI_SEL_LSB];
   always_comb begin
      case (smiSel)
         2'h0: smiTo = 1'b0;
         2'h1: smiTo = expPulse[0];
         2'h2: smiTo = expPulse[1];
         default: smiTo = |expPulse;
      endcase
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         idleTimeoutSmiEvent <= 1'b0;
      end else begin
         idleTimeoutSmiEvent <= smiTo | (|(fire & smiVec));
      end
   end
   // ---------------------------------------------------------------
   // Interrupt status: primary, secondary expiry, doze reset
   // ---------------------------------------------------------------
   logic [ddtc_pkg::STAT_W-1:0] statSet;
   assign statSet = {dozeReset & (state_r != ddtc_pkg::DOZE_FULL), expPulse};
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqStat_r <= '0;
         irqOut <= 1'b0;
      end else begin
         irqStat_r <= (statRead ? '0 : irqStat_r) | statSet;
         irqOut <= |(irqStat_r & irqMask_r[ddtc_pkg::STAT_W-1:0]);
      end
   end
   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign wrDo = awPend_r && wPend_r && !s_axi_bvalid;
   assign wrIdx = awAddr_r[9:2];
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         awPend_r <= 1'b0;
         wPend_r <= 1'b0;
         awAddr_r <= '0;
         wData_r <= '0;
         wStrb_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= ddtc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !awPend_r && !s_axi_awready;
         s_axi_wready <= !wPend_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            awPend_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wPend_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (wrDo) begin
            awPend_r <= 1'b0;
            wPend_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrHit && awAddr_r[1:0] == 2'h0) ? ddtc_pkg::RESP_OKAY
                                                             : ddtc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_comb begin
      if (awAddr_r[11:10] != 2'h0) begin
         wrHit = 1'b0;
      end else if (wrIdx == ddtc_pkg::IDX_CTRL_TWO || wrIdx == ddtc_pkg::IDX_SEL_DEV) begin
         wrHit = 1'b1;
      end else if (wrIdx == ddtc_pkg::IDX_SEL_IRQ_LO || wrIdx == ddtc_pkg::IDX_SEL_IRQ_HI) begin
         wrHit = 1'b1;
      end else if (wrIdx == ddtc_pkg::IDX_CTRL_ELEVEN || wrIdx == ddtc_pkg::IDX_EVENT_SIX) begin
         wrHit = 1'b1;
      end else if (wrIdx == ddtc_pkg::IDX_DOZE_CTRL || wrIdx == ddtc_pkg::IDX_RST_EN) begin
         wrHit = 1'b1;
      end else if (wrIdx == ddtc_pkg::IDX_SMI_EN || wrIdx == ddtc_pkg::IDX_IRQ_MASK) begin
         wrHit = 1'b1;
      end else begin
         wrHit = 1'b0;
      end
   end
   // Byte registers take lane 0 only
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrlTwo_r <= ddtc_pkg::RST_ZERO8;
         selDev_r <= ddtc_pkg::RST_SEL_DEV;
         selIrqLo_r <= ddtc_pkg::RST_ZERO8;
         selIrqHi_r <= ddtc_pkg::RST_ZERO8;
         ctrlEleven_r <= ddtc_pkg::RST_ZERO8;
         eventSix_r <= ddtc_pkg::RST_ZERO8;
         dozeCtrl_r <= ddtc_pkg::RST_ZERO8;
         irqMask_r <= ddtc_pkg::RST_ZERO8;
         rstEn_r <= '0;
         smiEn_r <= '0;
      end else begin
         if (dozeReset) begin
            dozeCtrl_r[ddtc_pkg::CTL_SW_STOP:ddtc_pkg::CTL_SW_SLOW] <= 2'h0;
         end
         if (wrDo && wrHit && awAddr_r[1:0] == 2'h0 && wStrb_r[0]) begin
            if (wrIdx == ddtc_pkg::IDX_CTRL_TWO) begin
               ctrlTwo_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_SEL_DEV) begin
               selDev_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_SEL_IRQ_LO) begin
               selIrqLo_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_SEL_IRQ_HI) begin
               selIrqHi_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_CTRL_ELEVEN) begin
               ctrlEleven_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_EVENT_SIX) begin
               eventSix_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_DOZE_CTRL) begin
               dozeCtrl_r <= wData_r[7:0];
            end else if (wrIdx == ddtc_pkg::IDX_IRQ_MASK) begin
               irqMask_r <= wData_r[7:0];
            end
         end
         if (wrDo && wrHit && awAddr_r[1:0] == 2'h0 && wrIdx == ddtc_pkg::IDX_RST_EN) begin
            rstEn_r <= ddtc_pkg::mergeStrb(rstEn_r, wData_r, wStrb_r);
         end
         if (wrDo && wrHit && awAddr_r[1:0] == 2'h0 && wrIdx == ddtc_pkg::IDX_SMI_EN) begin
            smiEn_r <= ddtc_pkg::mergeStrb(smiEn_r, wData_r, wStrb_r);
         end
      end
   end
   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   assign rdDo = s_axi_arvalid && s_axi_arready;
   assign rdIdx = s_axi_araddr[9:2];
   assign statRead = rdDo && rdHit && rdIdx == ddtc_pkg::IDX_IRQ_STAT;
   always_comb begin
      rdVal = '0;
      rdHit = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
      if (rdIdx == ddtc_pkg::IDX_CTRL_TWO) begin
         rdVal[7:0] = ctrlTwo_r;
      end else if (rdIdx == ddtc_pkg::IDX_SEL_DEV) begin
         rdVal[7:0] = selDev_r;
      end else if (rdIdx == ddtc_pkg::IDX_SEL_IRQ_LO) begin
         rdVal[7:0] = selIrqLo_r;
      end else if (rdIdx == ddtc_pkg::IDX_SEL_IRQ_HI) begin
         rdVal[7:0] = selIrqHi_r;
      end else if (rdIdx == ddtc_pkg::IDX_CTRL_ELEVEN) begin
         rdVal[7:0] = ctrlEleven_r;
      end else if (rdIdx == ddtc_pkg::IDX_EVENT_SIX) begin
         rdVal[7:0] = eventSix_r;
      end else if (rdIdx == ddtc_pkg::IDX_DOZE_CTRL) begin
         rdVal[7:0] = dozeCtrl_r;
      end else if (rdIdx == ddtc_pkg::IDX_RST_EN) begin
         rdVal = rstEn_r;
      end else if (rdIdx == ddtc_pkg::IDX_SMI_EN) begin
         rdVal = smiEn_r;
      end else if (rdIdx == ddtc_pkg::IDX_IRQ_STAT) begin
         rdVal[ddtc_pkg::STAT_W-1:0] = irqStat_r;
      end else if (rdIdx == ddtc_pkg::IDX_IRQ_MASK) begin
         rdVal[7:0] = irqMask_r;
      end else if (rdIdx == ddtc_pkg::IDX_STATE) begin
         rdVal[3:0] = {stopCpuClock, slowClock, expired_r};
      end else begin
         rdHit = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= ddtc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (rdDo) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdHit ? rdVal : '0;
            s_axi_rresp <= rdHit ? ddtc_pkg::RESP_OKAY : ddtc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- common/ddtc_pkg.sv ----
// Constants, field layouts and carriers of the dual doze timer control.
// Assumes a 25 MHz core clock and software access over AXI4-Lite.
// Summary of operation
// - Enter doze alone after inactivity, once set up
// - Optionally raise SMI around doze operation
// - Hardware slowdown, software slowdown, software clock stop
// - Shortest primary time-out is two milliseconds
// - Two timers; event reloads its selected one
// - Hardware doze only when both timers expired
// - Serial, parallel, general ranges default to secondary
// - Secondary no-delay setting inhibits its doze resets
// - SMI, external event, CPU interrupt use primary
// - Two-bit field selects timer expirations raising SMI
// - Each doze reset event may raise SMI
// - First select register maps device access sources
// - Second select register maps low interrupt requests
// - Third select register maps local bus, high IRQs
// - Primary codes: 2,4,8,32,128,512,2000,8000 ms
// - Secondary codes: 0,1,4,16,64,256,1000,4000 ms
// - Doze reset restores speed, reloads timer
// - Local bus select edge, qualified memory or I/O
package ddtc_pkg;
   // ---------------------------------------------------------------
   // Register indices; byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_CTRL_TWO = 8'h41;
   localparam logic [7:0] IDX_SEL_DEV = 8'h76;
   localparam logic [7:0] IDX_SEL_IRQ_LO = 8'h77;
   localparam logic [7:0] IDX_SEL_IRQ_HI = 8'h78;
   localparam logic [7:0] IDX_CTRL_ELEVEN = 8'h79;
   localparam logic [7:0] IDX_EVENT_SIX = 8'hD9;
   localparam logic [7:0] IDX_DOZE_CTRL = 8'hE0;
   localparam logic [7:0] IDX_RST_EN = 8'hE1;
   localparam logic [7:0] IDX_SMI_EN = 8'hE2;
   localparam logic [7:0] IDX_IRQ_STAT = 8'hE3;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hE4;
   localparam logic [7:0] IDX_STATE = 8'hE5;
   // ---------------------------------------------------------------
   // Reset values and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_ZERO8 = 8'h00;
   localparam logic [7:0] RST_SEL_DEV = 8'h0F;
   localparam int TO_MSB = 7;
   localparam int TO_LSB = 5;
   localparam int DEV_RST_EN_BIT = 1;
   localparam int SMI_SEL_MSB = 7;
   localparam int SMI_SEL_LSB = 6;
   localparam int CTL_HW_EN = 0;
   localparam int CTL_SW_SLOW = 1;
   localparam int CTL_SW_STOP = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_TICK_NS = 1000000;
   localparam int MS_TICK_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 13;
   localparam int STAT_W = 3;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic intr;
      logic smi;
      logic epmi;
      logic local_bus_device_select_n;
      logic [15:0] irq;
      logic [7:0] dev;
   } ddtc_src_t;
   localparam int SRC_W = $bits(ddtc_src_t);
   typedef enum {DOZE_FULL, DOZE_SLOW, DOZE_STOP} ddtc_state_t;
   // Primary time-out in ms
   function automatic logic [CNT_W-1:0] primMs(input logic [2:0] code);
      case (code)
         3'h0: primMs = 13'h0002;
         3'h1: primMs = 13'h0004;
         3'h2: primMs = 13'h0008;
         3'h3: primMs = 13'h0020;
         3'h4: primMs = 13'h0080;
         3'h5: primMs = 13'h0200;
         3'h6: primMs = 13'h07D0;
         default: primMs = 13'h1F40;
      endcase
   endfunction
   // Secondary time-out in ms; zero means no delay
   function automatic logic [CNT_W-1:0] secMs(input logic [2:0] code);
      case (code)
         3'h0: secMs = 13'h0000;
         3'h1: secMs = 13'h0001;
         3'h2: secMs = 13'h0004;
         3'h3: secMs = 13'h0010;
         3'h4: secMs = 13'h0040;
         3'h5: secMs = 13'h0100;
         3'h6: secMs = 13'h03E8;
         default: secMs = 13'h0FA0;
      endcase
   endfunction
   function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
      mergeStrb = old;
   endfunction
endpackage

// ---- dv/ddtc_activity_model.sv ----
// Activity sources seen by the doze timer control.
// Called by the bench just after a rising clock edge.
`timescale 1ns/1ps
module ddtc_activity_model (
   // Clock
   input wire logic ref_clk,
   // Activity pins
   output logic [7:0] deviceActivity,
   output logic [15:0] irqLine,
   output logic localBusDeviceSelectN,
   output logic memIoSel,
   output logic externalPowerEventIn,
   output logic smiIn,
   output logic cpuIntr
);
   ddtc_pkg::ddtc_src_t src = '0;
   assign deviceActivity = src.dev;
   assign irqLine = src.irq;
   assign localBusDeviceSelectN = ~src.local_bus_device_select_n;
   assign memIoSel = 1'b1;
   assign externalPowerEventIn = src.epmi;
   assign smiIn = src.smi;
   assign cpuIntr = src.intr;
   task automatic fire(input ddtc_pkg::ddtc_src_t ev);
      src <= ev;
      repeat (4) @(posedge ref_clk);
      src <= '0;
      @(posedge ref_clk);
   endtask
endmodule

// ---- dv/ddtc_monitor.sv ----
// Port checker for the doze timer control.
// Bound into ddtc_top; sees its ports only.
`timescale 1ns/1ps
module ddtc_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Doze outputs
   input wire logic slowClock,
   input wire logic stopCpuClock,
   input wire logic idleTimeoutSmiEvent,
   input wire logic irqOut
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready held");
   a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   a_stop_slow: assert property (stopCpuClock |-> slowClock)
      else $error("stop without doze");
   a_smi_pulse: assert property (idleTimeoutSmiEvent |=> !idleTimeoutSmiEvent)
      else $error("smi pulse too long");
   a_irq_level: assert property ($rose(irqOut) && !s_axi_arvalid |=> irqOut)
      else $error("irq not level");
endmodule
bind ddtc_top ddtc_monitor ddtc_monitor_inst (.ref_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .slowClock, .stopCpuClock, .idleTimeoutSmiEvent, .irqOut);

// ---- dv/tb_top.sv ----
// Self-checking bench for the doze timer control.
// Bus driven here; activity through the partner model.
`timescale 1ns/1ps
module tb_top;
   localparam int T = 10;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] awAddr = '0, arAddr = '0;
   logic [31:0] wData = '0, rData;
   logic [3:0] wStrb = 4'hF;
   logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic awReady, wReady, bValid, arReady, rValid, slowClk, stopClk, smiEv, irqO;
   logic [1:0] bResp, rResp;
   logic [7:0] devAct;
   logic [15:0] irqL;
   logic ldevN, memIo, epmi, smi, intr;
   int n_errors = 0, n_checks = 0, cyc = 0, smiCnt = 0;
   ddtc_pkg::ddtc_src_t wake, ser;
   ddtc_top #(.TICK_CYCLES(T)) ddtc_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .deviceActivity(devAct), .irqLine(irqL), .localBusDeviceSelectN(ldevN),
      .memIoSel(memIo), .externalPowerEventIn(epmi), .smiIn(smi), .cpuIntr(intr),
      .slowClock(slowClk), .stopCpuClock(stopClk), .idleTimeoutSmiEvent(smiEv), .irqOut(irqO));
   ddtc_activity_model ddtc_activity_model_inst (.ref_clk(ref_clk), .deviceActivity(devAct),
      .irqLine(irqL), .localBusDeviceSelectN(ldevN), .memIoSel(memIo),
      .externalPowerEventIn(epmi), .smiIn(smi), .cpuIntr(intr));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (smiEv === 1'b1) smiCnt <= smiCnt + 1;
      if (cyc == 30000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      awAddr <= {2'h0, idx, 2'h0};
      wData <= d;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
      end while (!bValid);
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      arAddr <= {2'h0, idx, 2'h0};
      arValid <= 1'b1;
      rReady <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arReady) arValid <= 1'b0;
      end while (!rValid);
      d = rData;
      r = rResp;
   endtask
   task automatic waitLvl(input logic lvl, output int n);
      n = 0;
      while (slowClk !== lvl && n < 400) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      logic [7:0] idx [6] = '{8'h41, 8'h76, 8'h77, 8'h78, 8'h79, 8'hD9};
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 6; i++) begin
         rd(idx[i], d, r);
         chk(d, (i == 1) ? 32'h0F : 32'h0);
      end
      rd(8'h10, d, r);
      chk({r, d[29:0]}, 32'h80000000);
      wr(8'h77, 32'hFFFFFFA5);
      rd(8'h77, d, r);
      chk(d, 32'hA5);
      $display("t_regs done");
   endtask
   task automatic t_hw();
      int n;
      wr(8'hE1, 32'h08000008);
      wr(8'hE0, 32'h1);
      waitLvl(1'b1, n);
      chk(32'(slowClk), 32'h1);
      for (int c = 0; c < 3; c++) begin
         wr(8'h41, {24'h0, c[2:0], 5'h0});
         ddtc_activity_model_inst.fire(wake);
         waitLvl(1'b0, n);
         chk(32'(n < 12), 32'h1);
         waitLvl(1'b1, n);
         chk(32'(n >= (T << (c + 1)) - 14 && n <= (T << (c + 1)) + 10), 32'h1);
      end
      $display("t_hw done");
   endtask
   task automatic t_sec();
      int n;
      wr(8'h79, 32'h40);
      ddtc_activity_model_inst.fire(ser);
      waitLvl(1'b0, n);
      chk(32'(n < 12), 32'h1);
      waitLvl(1'b1, n);
      chk(32'(n >= 4 * T - 14 && n <= 4 * T + 10), 32'h1);
      wr(8'h79, 32'h0);
      ddtc_activity_model_inst.fire(ser);
      repeat (T) @(posedge ref_clk);
      chk(32'(slowClk), 32'h1);
      $display("t_sec done");
   endtask
   task automatic t_smi();
      logic [31:0] d;
      logic [1:0] r;
      int n, s;
      wr(8'hE4, 32'h1);
      for (int c = 0; c < 4; c++) begin
         wr(8'hD9, {24'h0, c[1:0], 6'h0});
         rd(8'hE3, d, r);
         s = smiCnt;
         ddtc_activity_model_inst.fire(wake);
         waitLvl(1'b0, n);
         waitLvl(1'b1, n);
         repeat (3) @(posedge ref_clk);
         chk(32'(smiCnt - s), {31'h0, c[0]});
         chk(32'(irqO), 32'h1);
         rd(8'hE3, d, r);
         chk({31'h0, d[0]}, 32'h1);
         repeat (3) @(posedge ref_clk);
         chk(32'(irqO), 32'h0);
      end
      $display("t_smi done");
   endtask
   task automatic t_sw();
      int n;
      ddtc_activity_model_inst.fire(wake);
      wr(8'hE0, 32'h4);
      repeat (3) @(posedge ref_clk);
      chk({30'h0, slowClk, stopClk}, 32'h3);
      ddtc_activity_model_inst.fire(wake);
      waitLvl(1'b0, n);
      chk(32'(stopClk), 32'h0);
      wr(8'hE0, 32'h2);
      repeat (3) @(posedge ref_clk);
      chk({30'h0, slowClk, stopClk}, 32'h2);
      ddtc_activity_model_inst.fire(wake);
      repeat (4 * T) @(posedge ref_clk);
      chk(32'(slowClk), 32'h0);
      $display("t_sw done");
   endtask
   initial begin
      wake = '0;
      wake.intr = 1'b1;
      ser = '0;
      ser.dev[3] = 1'b1;
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_regs();
      t_hw();
      t_sec();
      t_smi();
      t_sw();
      finish_test();
   end
endmodule
